//--- src/rtc_alarm_top.sv
`timescale 1ns/100ps
`include "rtc_defines.svh"
module rtc_alarm_top #(
  parameter logic [15:0] LF_PER_SEC = `RTC_LF_PER_SEC
) (
  // clock, reset, enable
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic CE_I,
  // low-frequency timebase
  input wire logic LF_CLK_I,
  // indexed host port
  input wire rtc_pkg::rtc_host_req_type HOST_REQ_I,
  output logic [7:0] HOST_RDATA_O,
  // power manager side
  input wire logic [1:0] PM_STATE_I,
  input wire logic PM_OTHER_WAKE_I,
  input wire logic [1:0] PM_OTHER_SRC_I,
  output logic PM_WAKE_O,
  output logic ALARM_IRQ_O
);
  import rtc_pkg::*;

  // ------------------------------------------------
  // declarations
  // ------------------------------------------------
  rtc_state_type s;
  rtc_state_type n;
  logic lf_rise;
  logic sec_tick;
  logic time_eq;
  logic day_eq;
  logic alarm_hit;
  logic pm_low;
  logic host_wr_idx;
  logic host_wr_data;
  logic host_rd_data;
  logic ram_hit;
  logic [7:0] ram_q;
  logic [7:0] status_val;
  logic [7:0] pm_status_val;

  // ------------------------------------------------
  // host strobes and decode
  // ------------------------------------------------
  assign host_wr_idx = HOST_REQ_I.wr & ~HOST_REQ_I.sel_data;
  assign host_wr_data = HOST_REQ_I.wr & HOST_REQ_I.sel_data;
  assign host_rd_data = HOST_REQ_I.rd & HOST_REQ_I.sel_data;
  assign ram_hit = (s.index >= `RTC_IDX_RAM_LO) &&
                   (s.index <= `RTC_IDX_RAM_HI);
  assign pm_low = (PM_STATE_I == `RTC_PM_OFF) ||
                  (PM_STATE_I == `RTC_PM_SUSPEND);

  // ------------------------------------------------
  // status views
  // ------------------------------------------------
  always_comb begin
    status_val = `RTC_READ_ZERO;
    status_val[`RTC_STAT_FLAG] = s.alarm_flag;
    status_val[`RTC_STAT_ARMED] = s.mode[`RTC_MODE_ALM_EN];
  end

  always_comb begin
    pm_status_val = `RTC_READ_ZERO;
    pm_status_val[`RTC_PS_SRC_LSB +: 2] = s.wake_src;
    pm_status_val[`RTC_PS_STATE_LSB +: 2] = PM_STATE_I;
  end

  // ------------------------------------------------
  // next-state logic
  // ------------------------------------------------
  always_comb begin
    n = s;
    n.wake = 1'b0;
    n.lf_q = LF_CLK_I;
    sec_tick = 1'b0;
    time_eq = 1'b0;
    day_eq = 1'b0;
    alarm_hit = 1'b0;
    lf_rise = LF_CLK_I & ~s.lf_q;
    if (lf_rise) begin
      if (s.div >= LF_PER_SEC - 16'h0001) begin
        n.div = '0;
        sec_tick = 1'b1;
      end else begin
        n.div = s.div + 16'h0001;
      end
    end
    if (sec_tick) begin
      if (s.sec >= `RTC_SEC_MAX) begin
        n.sec = '0;
        if (s.min >= `RTC_MIN_MAX) begin
          n.min = '0;
          if (s.hr >= `RTC_HR_MAX) begin
            n.hr = '0;
            n.day = s.day + 16'h0001;
          end else begin
            n.hr = s.hr + 8'h01;
          end
        end else begin
          n.min = s.min + 8'h01;
        end
      end else begin
        n.sec = s.sec + 8'h01;
      end
    end
    time_eq = (n.sec == s.a_sec) && (n.min == s.a_min) &&
              (n.hr == s.a_hr);
    day_eq = ~s.mode[`RTC_MODE_DAY32] ||
             (n.day[7:0] == s.a_day);
    alarm_hit = sec_tick & s.mode[`RTC_MODE_ALM_EN] &
                time_eq & day_eq;
    if (host_wr_idx) begin
      n.index = HOST_REQ_I.wdata;
    end
    if (host_wr_data) begin
      case (s.index)
        `RTC_IDX_SEC: begin
          n.sec = HOST_REQ_I.wdata;
        end
        `RTC_IDX_MIN: begin
          n.min = HOST_REQ_I.wdata;
        end
        `RTC_IDX_HR: begin
          n.hr = HOST_REQ_I.wdata;
        end
        `RTC_IDX_DAY_LO: begin
          n.day[7:0] = HOST_REQ_I.wdata;
        end
        `RTC_IDX_DAY_HI: begin
          n.day[15:8] = HOST_REQ_I.wdata;
        end
        `RTC_IDX_ASEC: begin
          n.a_sec = HOST_REQ_I.wdata;
        end
        `RTC_IDX_AMIN: begin
          n.a_min = HOST_REQ_I.wdata;
        end
        `RTC_IDX_AHR: begin
          n.a_hr = HOST_REQ_I.wdata;
        end
        `RTC_IDX_ADAY: begin
          n.a_day = HOST_REQ_I.wdata;
        end
        `RTC_IDX_MODE: begin
          n.mode = HOST_REQ_I.wdata;
        end
        default: begin
          n.mode = n.mode;
        end
      endcase
    end
    // flag cleared by status read
    if (host_rd_data && s.index == `RTC_IDX_STATUS) begin
      n.alarm_flag = 1'b0;
    end
    // set wins, wake only when enabled
    if (alarm_hit) begin
      n.alarm_flag = 1'b1;
    end
    // other source kept unless the alarm wakes
    if (alarm_hit && s.mode[`RTC_MODE_WAKE_EN] && pm_low) begin
      n.wake = 1'b1;
      n.wake_src = `RTC_WAKE_SRC_ALARM;
    end else if (PM_OTHER_WAKE_I) begin
      n.wake_src = PM_OTHER_SRC_I;
    end
    // register read path
    if (HOST_REQ_I.rd) begin
      n.rd_ram = HOST_REQ_I.sel_data & ram_hit;
      if (!HOST_REQ_I.sel_data) begin
        n.rdata = s.index;
      end else begin
        case (s.index)
          `RTC_IDX_SEC: begin
            n.rdata = s.sec;
          end
          `RTC_IDX_MIN: begin
            n.rdata = s.min;
          end
          `RTC_IDX_HR: begin
            n.rdata = s.hr;
          end
          `RTC_IDX_DAY_LO: begin
            n.rdata = s.day[7:0];
          end
          `RTC_IDX_DAY_HI: begin
            n.rdata = s.day[15:8];
          end
          `RTC_IDX_ASEC: begin
            n.rdata = s.a_sec;
          end
          `RTC_IDX_AMIN: begin
            n.rdata = s.a_min;
          end
          `RTC_IDX_AHR: begin
            n.rdata = s.a_hr;
          end
          `RTC_IDX_ADAY: begin
            n.rdata = s.a_day;
          end
          `RTC_IDX_MODE: begin
            n.rdata = s.mode;
          end
          `RTC_IDX_STATUS: begin
            n.rdata = status_val;
          end
          `RTC_IDX_PM_STATUS: begin
            n.rdata = pm_status_val;
          end
          default: begin
            n.rdata = `RTC_READ_ZERO;
          end
        endcase
      end
    end
  end

  // ------------------------------------------------
  // state register, frozen while enable low
  // ------------------------------------------------
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      s <= '0;
    end else if (CE_I) begin
      s <= n;
    end
  end

  // ------------------------------------------------
  // storage bytes
  // ------------------------------------------------
  // 64 bytes behind indices 80h..bfh
  rtc_cmos_ram #(
    .AW(`RTC_RAM_AW),
    .DW(8)
  ) i_rtc_cmos_ram (
    .clk_i(CLK_I),
    .rstn_i(RSTN_I),
    .we_i(CE_I & host_wr_data & ram_hit),
    .re_i(CE_I & host_rd_data & ram_hit),
    .addr_i(s.index[`RTC_RAM_AW-1:0]),
    .wdata_i(HOST_REQ_I.wdata),
    .rdata_o(ram_q)
  );

  // ------------------------------------------------
  // outputs
  // ------------------------------------------------
  assign HOST_RDATA_O = s.rd_ram ? ram_q : s.rdata;
  assign PM_WAKE_O = s.wake;
  assign ALARM_IRQ_O = s.alarm_flag;

  // ------------------------------------------------
  // checks
  // ------------------------------------------------
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RSTN_I);

  sequence s_idx_write;
    CE_I && host_wr_idx;
  endsequence

  sequence s_sec_wrap;
    CE_I && sec_tick && !host_wr_data &&
      s.sec == `RTC_SEC_MAX;
  endsequence

  sequence s_flag_rise;
    CE_I && !host_wr_data && !s.alarm_flag ##1 s.alarm_flag;
  endsequence

  a_tick_wrap: assert property (CE_I && sec_tick |=> s.div == '0)
    else $error("divider not cleared on tick");

  // divider moves only on timebase edges
  a_div_hold: assert property (
    CE_I && !lf_rise |=> s.div == $past(s.div))
    else $error("divider moved without timebase edge");

  a_sec_carry: assert property (
    s_sec_wrap |=> s.sec == '0 &&
    (s.min == '0 || s.min == $past(s.min) + 8'h01))
    else $error("seconds carry wrong");

  a_alarm_set: assert property (
    CE_I && alarm_hit |=> s.alarm_flag && ALARM_IRQ_O)
    else $error("alarm match lost");

  // raised flag means time equals alarm
  a_time_match: assert property (
    s_flag_rise |-> s.sec == s.a_sec && s.min == s.a_min &&
    s.hr == s.a_hr)
    else $error("alarm raised at wrong time");

  a_alarm_off: assert property (
    CE_I && !s.mode[`RTC_MODE_ALM_EN] && !s.alarm_flag |=>
    !s.alarm_flag)
    else $error("alarm raised while disabled");

  // status read clears a quiet flag
  a_flag_clear: assert property (
    CE_I && host_rd_data && s.index == `RTC_IDX_STATUS &&
    !alarm_hit |=> !s.alarm_flag)
    else $error("flag not cleared by status read");

  // 32-day alarm only on chosen day
  a_day_gate: assert property (
    s_flag_rise |-> !s.mode[`RTC_MODE_DAY32] ||
    s.day[7:0] == s.a_day)
    else $error("32-day alarm on wrong day");

  // wake needs enable and low state
  a_wake_gate: assert property (
    CE_I && !s.wake ##1 s.wake |->
    $past(s.mode[`RTC_MODE_WAKE_EN]) && $past(pm_low))
    else $error("wake without enable");

  // no wake outside enable and low state
  a_wake_refused: assert property (
    CE_I && !(s.mode[`RTC_MODE_WAKE_EN] && pm_low) |=> !PM_WAKE_O)
    else $error("wake while refused");

  a_wake_pulse: assert property (
    CE_I && PM_WAKE_O |=> !PM_WAKE_O)
    else $error("wake longer than one cycle");

  a_wake_src: assert property (
    PM_WAKE_O |-> s.wake_src == `RTC_WAKE_SRC_ALARM)
    else $error("wake source not alarm");

  // index register loads the written value
  a_idx_load: assert property (
    s_idx_write |=> s.index == $past(HOST_REQ_I.wdata))
    else $error("index not loaded");

endmodule : rtc_alarm_top

//--- src/rtc_defines.svh
// How it works
// - timebase runs from continuous low-frequency clock
// - counters, mode and status registers provided
// - 64 storage bytes at indices 80h..bfh
// - storage reached only through index/data pair
// - storage never cleared while powered
// - alarm in time-of-day or 32-day mode
// - alarm wakes manager only with wake enable
// - time-of-day alarm repeats daily until disabled
// - 32-day alarm fires on one chosen day
// - manager status bits 6:5 show alarm wake
`ifndef RTC_DEFINES_SVH
`define RTC_DEFINES_SVH
// ------------------------------------------------
// register indices
// ------------------------------------------------
`define RTC_IDX_SEC 8'h70
`define RTC_IDX_MIN 8'h71
`define RTC_IDX_HR 8'h72
`define RTC_IDX_DAY_LO 8'h73
`define RTC_IDX_DAY_HI 8'h74
`define RTC_IDX_ASEC 8'h75
`define RTC_IDX_AMIN 8'h76
`define RTC_IDX_AHR 8'h77
`define RTC_IDX_ADAY 8'h78
`define RTC_IDX_MODE 8'h79
`define RTC_IDX_STATUS 8'h7a
`define RTC_IDX_RAM_LO 8'h80
`define RTC_IDX_RAM_HI 8'hbf
`define RTC_IDX_PM_STATUS 8'hc0
// ------------------------------------------------
// fields and codes
// ------------------------------------------------
`define RTC_MODE_ALM_EN 0
`define RTC_MODE_DAY32 1
`define RTC_MODE_WAKE_EN 2
`define RTC_STAT_FLAG 0
`define RTC_STAT_ARMED 1
`define RTC_PS_SRC_LSB 5
`define RTC_PS_STATE_LSB 0
`define RTC_WAKE_SRC_ALARM 2'h2
`define RTC_PM_OFF 2'h3
`define RTC_PM_SUSPEND 2'h2
`define RTC_RAM_AW 6
// ------------------------------------------------
// counter limits and timebase
// ------------------------------------------------
`define RTC_SEC_MAX 8'h3b
`define RTC_MIN_MAX 8'h3b
`define RTC_HR_MAX 8'h17
`define RTC_LF_PER_SEC 16'h8000
`define RTC_READ_ZERO 8'h00
`endif

//--- src/rtc_pkg.sv
package rtc_pkg;

  // ------------------------------------------------
  // host request on the index/data port
  // ------------------------------------------------
  typedef struct packed {
    logic sel_data;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } rtc_host_req_type;

  // ------------------------------------------------
  // whole state of the clock block
  // ------------------------------------------------
  typedef struct packed {
    logic [7:0] index;
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hr;
    logic [15:0] day;
    logic [7:0] a_sec;
    logic [7:0] a_min;
    logic [7:0] a_hr;
    logic [7:0] a_day;
    logic [7:0] mode;
    logic alarm_flag;
    logic [1:0] wake_src;
    logic [15:0] div;
    logic lf_q;
    logic [7:0] rdata;
    logic rd_ram;
    logic wake;
  } rtc_state_type;

endpackage : rtc_pkg

//--- src/rtc_cmos_ram.sv
`timescale 1ns/100ps
module rtc_cmos_ram #(
  parameter int AW = 6,
  parameter int DW = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // access port
  input wire logic we_i,
  input wire logic re_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  output logic [DW-1:0] rdata_o
);

  // ------------------------------------------------
  // storage, never reset
  // ------------------------------------------------
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
  end

  // ------------------------------------------------
  // registered read data
  // ------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= '0;
    end else if (re_i) begin
      rdata_o <= mem[addr_i];
    end
  end

endmodule : rtc_cmos_ram

//--- bench/rtc_alarm_wake_cmos_ram_bench.sv
`timescale 1ns/100ps
module rtc_alarm_wake_cmos_ram_bench;
  import rtc_pkg::*;
  // ------------------------------------------------
  // signals
  // ------------------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic lf_clk = 1'b0;
  rtc_host_req_type req = '0;
  logic [7:0] rdata;
  logic [1:0] pm_state = 2'h0;
  logic oth_wake = 1'b0;
  logic [1:0] oth_src = 2'h0;
  logic wake;
  logic irq;
  logic pend = 1'b0;
  logic [7:0] exp_q[$];
  string name_q[$];
  int n_fail = 0;
  int comparisons = 0;
  int n_wake = 0;
  int cycles = 0;
  logic [7:0] d0;
  logic [7:0] d1;

  rtc_alarm_top #(.LF_PER_SEC(16'h0004)) i_rtc_alarm_top (
    .CLK_I(clk),
    .RSTN_I(rst_n),
    .CE_I(ce),
    .LF_CLK_I(lf_clk),
    .HOST_REQ_I(req),
    .HOST_RDATA_O(rdata),
    .PM_STATE_I(pm_state),
    .PM_OTHER_WAKE_I(oth_wake),
    .PM_OTHER_SRC_I(oth_src),
    .PM_WAKE_O(wake),
    .ALARM_IRQ_O(irq)
  );

  initial begin
    forever #4 clk = ~clk;
  end

  // ------------------------------------------------
  // report and compare
  // ------------------------------------------------
  task automatic close_out;
    $display("compared %0d, failed %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out

  task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // ------------------------------------------------
  // monitor: read answer one edge after request
  // ------------------------------------------------
  always @(posedge clk) pend <= req.rd;
  always @(negedge clk) begin
    if (pend && exp_q.size() > 0)
      chk(name_q.pop_front(), exp_q.pop_front(), rdata);
  end
  always @(negedge clk) begin
    if (wake === 1'b1)
      n_wake++;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      close_out();
    end
  end

  // ------------------------------------------------
  // drivers
  // ------------------------------------------------
  task automatic xfer(logic s, logic w, logic r, logic [7:0] d);
    @(negedge clk);
    req = '{s, w, r, d};
  endtask : xfer

  task automatic wr(logic [7:0] i, logic [7:0] d);
    xfer(1'b0, 1'b1, 1'b0, i);
    xfer(1'b1, 1'b1, 1'b0, d);
    xfer(1'b0, 1'b0, 1'b0, 8'h00);
  endtask : wr

  task automatic rd(logic [7:0] i, logic [7:0] e, string nm);
    xfer(1'b0, 1'b1, 1'b0, i);
    xfer(1'b1, 1'b0, 1'b1, 8'h00);
    exp_q.push_back(e);
    name_q.push_back(nm);
    xfer(1'b0, 1'b0, 1'b0, 8'h00);
  endtask : rd

  task automatic lf(int n);
    repeat (n) begin
      @(negedge clk);
      lf_clk = 1'b1;
      repeat (3) @(negedge clk);
      lf_clk = 1'b0;
      repeat (3) @(negedge clk);
    end
  endtask : lf

  task automatic set_time(logic [7:0] h, logic [7:0] m, logic [7:0] s);
    wr(8'h72, h);
    wr(8'h71, m);
    wr(8'h70, s);
  endtask : set_time

  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    void'($urandom(32'hdb63));
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    rd(8'h79, 8'h00, "mode reset");
    wr(8'h70, 8'h2a);
    rd(8'h70, 8'h2a, "seconds");
    ce = 1'b0;
    wr(8'h71, 8'h11);
    ce = 1'b1;
    rd(8'h71, 8'h00, "frozen write");
    wr(8'h74, 8'h5a);
    rd(8'h74, 8'h5a, "day high");
    wr(8'h79, 8'hf8);
    rd(8'h79, 8'hf8, "mode");
    wr(8'h7a, 8'hff);
    rd(8'h7a, 8'h00, "status read only");
    rd(8'h7b, 8'h00, "unmapped");
    $display("test registers done");
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    wr(8'h80, d0);
    wr(8'hbf, d1);
    rd(8'h80, d0, "storage first");
    rd(8'hbf, d1, "storage last");
    xfer(1'b0, 1'b0, 1'b1, 8'h00);
    exp_q.push_back(8'hbf);
    name_q.push_back("index readback");
    xfer(1'b0, 1'b0, 1'b0, 8'h00);
    $display("test storage done");
    @(negedge clk);
    oth_src = 2'h1;
    oth_wake = 1'b1;
    @(negedge clk);
    oth_wake = 1'b0;
    rd(8'hc0, 8'h20, "other source");
    pm_state = 2'h3;
    wr(8'h75, 8'h00);
    wr(8'h76, 8'h00);
    wr(8'h77, 8'h00);
    wr(8'h73, 8'h00);
    set_time(8'h17, 8'h3b, 8'h3a);
    wr(8'h79, 8'h05);
    lf(4);
    chk("early alarm", 8'h00, {7'h0, irq});
    lf(4);
    chk("alarm", 8'h01, {7'h0, irq});
    chk("wakes", 8'h01, 8'(n_wake));
    rd(8'h70, 8'h00, "seconds wrap");
    rd(8'h72, 8'h00, "hours wrap");
    rd(8'h73, 8'h01, "day carry");
    rd(8'hc0, 8'h43, "wake source");
    rd(8'h7a, 8'h03, "status flag");
    rd(8'h7a, 8'h02, "status cleared");
    chk("alarm cleared", 8'h00, {7'h0, irq});
    set_time(8'h17, 8'h3b, 8'h3b);
    lf(4);
    chk("next day wakes", 8'h02, 8'(n_wake));
    rd(8'h7a, 8'h03, "next day flag");
    $display("test time of day done");
    pm_state = 2'h0;
    set_time(8'h17, 8'h3b, 8'h3b);
    lf(4);
    rd(8'h7a, 8'h03, "flag while on");
    chk("no wake while on", 8'h02, 8'(n_wake));
    wr(8'h79, 8'h04);
    set_time(8'h17, 8'h3b, 8'h3b);
    lf(4);
    chk("disabled alarm", 8'h00, {7'h0, irq});
    pm_state = 2'h2;
    wr(8'h79, 8'h05);
    set_time(8'h17, 8'h3b, 8'h3b);
    lf(4);
    chk("suspend wakes", 8'h03, 8'(n_wake));
    rd(8'hc0, 8'h42, "suspend source");
    rd(8'h7a, 8'h03, "suspend flag");
    $display("test wake gating done");
    wr(8'h79, 8'h03);
    wr(8'h78, 8'h05);
    rd(8'h78, 8'h05, "alarm day");
    wr(8'h73, 8'h01);
    set_time(8'h17, 8'h3b, 8'h3b);
    lf(4);
    rd(8'h7a, 8'h02, "wrong day");
    wr(8'h73, 8'h04);
    set_time(8'h17, 8'h3b, 8'h3b);
    lf(4);
    rd(8'h7a, 8'h03, "chosen day");
    chk("no wake enable", 8'h03, 8'(n_wake));
    @(negedge clk);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    rd(8'h79, 8'h00, "mode after reset");
    rd(8'h80, d0, "storage kept");
    chk("irq after reset", 8'h00, {7'h0, irq});
    $display("test day mode done");
    repeat (4) @(negedge clk);
    close_out();
  end
endmodule : rtc_alarm_wake_cmos_ram_bench
